/* File: verilog/lcdt_defines.svh */
`ifndef LCDT_DEFINES_SVH
`define LCDT_DEFINES_SVH

// ==========================================================
// Geometry
`define LCDT_COLS 32
`define LCDT_ROWS 4
`define LCDT_BITS_PER_BYTE 8
`define LCDT_PTR_ZERO 5'h00

// ==========================================================
// Timing
// Fixed frame division of the active clock
`define LCDT_FRAME_DIV 5'h18
`define LCDT_FRAME_LAST 5'h17
`define LCDT_HALF_FRAME 5'h0c
// Last count of the internal oscillator half period (four system clocks)
`define LCDT_OSC_HALF_LAST 3'h3
// Row slot lengths within one half frame, per mode
`define LCDT_SLOT_MUX2 5'h06
`define LCDT_SLOT_MUX3 5'h04
`define LCDT_SLOT_MUX4 5'h03

// ==========================================================
// Drive levels: ground, one third, two thirds, full LCD supply
`define LCDT_LVL_VSS 2'h0
`define LCDT_LVL_THIRD 2'h1
`define LCDT_LVL_TWO_THIRD 2'h2
`define LCDT_LVL_VLCD 2'h3

`endif

/* File: verilog/lcdt_pkg.sv */
package lcdt_pkg;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      lcdt_static,
      lcdt_mux2,
      lcdt_mux3,
      lcdt_mux4
   } lcdt_mode_t;

   typedef logic [1:0] lcdt_level_t;

endpackage : lcdt_pkg

/* File: verilog/lcdt_ram.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdt_defines.svh"

module lcdt_ram import lcdt_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire lcdt_mode_t drive_mode,
   input wire logic ptr_load,
   input wire logic [4:0] ptr_value,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic [31:0][3:0] ram_bits,
   output logic [4:0] ptr
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [31:0][3:0] mem;
      logic [4:0] ptr;
   } lcdt_ram_state_t;

   lcdt_ram_state_t s;
   lcdt_ram_state_t next_s;

   // Column offset and row of byte bit i (i = 0 is the MSB)
   function automatic logic [4:0] place(lcdt_mode_t m, logic [2:0] i);
      logic [2:0] off;
      logic [1:0] row;
      off = i;
      row = 2'h0;
      unique case (m)
         lcdt_static: begin
            off = i;
            row = 2'h0;
         end
         lcdt_mux2: begin
            off = {1'b0, i[2:1]};
            row = {1'b0, i[0]};
         end
         lcdt_mux3: begin
            off = 3'(i / 3'h3);
            row = 2'(i % 3'h3);
         end
         lcdt_mux4: begin
            off = {2'b00, i[2]};
            row = i[1:0];
         end
      endcase
      return {off, row};
   endfunction : place

   // Columns consumed by one byte
   function automatic logic [4:0] advance(lcdt_mode_t m);
      logic [4:0] a;
      a = 5'h08;
      unique case (m)
         lcdt_static: a = 5'h08;
         lcdt_mux2: a = 5'h04;
         lcdt_mux3: a = 5'h03;
         lcdt_mux4: a = 5'h02;
      endcase
      return a;
   endfunction : advance

   // ==========================================================
   // Byte packing and pointer
   always_comb begin
      logic [4:0] pl;
      logic [4:0] col;
      pl = 5'h00;
      col = 5'h00;
      next_s = s;
      if (ptr_load) begin
         next_s.ptr = ptr_value;
      end else if (byte_valid) begin
         for (int i = 0; i < `LCDT_BITS_PER_BYTE; i++) begin
            pl = place(drive_mode, 3'(i));
            col = 5'(s.ptr + {2'b00, pl[4:2]});
            next_s.mem[col][pl[1:0]] = byte_data[7 - i];
         end
         next_s.ptr = 5'(s.ptr + advance(drive_mode));
      end
   end

   // Register the state
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0; // RAM and pointer cleared
      end else begin
         s <= next_s;
      end
   end

   assign ram_bits = s.mem;
   assign ptr = s.ptr;

   // ==========================================================
   // Checks
   a_ptr_advance: assert property (@(posedge clk) disable iff (rst)
      byte_valid && !ptr_load && drive_mode == lcdt_mux3
      |=> ptr == 5'($past(ptr) + 5'h03))
      else $error("pointer did not advance by three");

   a_static_write: assert property (@(posedge clk) disable iff (rst)
      byte_valid && !ptr_load && drive_mode == lcdt_static
      |=> ram_bits[$past(ptr)][0] == $past(byte_data[7]))
      else $error("static byte MSB not in first column");

   a_mux3_keep: assert property (@(posedge clk) disable iff (rst)
      byte_valid && !ptr_load && drive_mode == lcdt_mux3
      |=> ram_bits[5'($past(ptr) + 5'h02)][2]
         == $past(ram_bits[5'(ptr + 5'h02)][2]))
      else $error("third column row two was modified");

endmodule : lcdt_ram
`default_nettype wire

/* File: verilog/lcdt_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdt_defines.svh"

// Notes on behaviour
// - Select high: clock pin is input
// - Frame rate is active clock over 24
// - Cascade sync keeps drivers in step
// - Timing copies RAM into display register
// - Four backplanes shaped by drive mode
// - Three-backplane mode: backplane 3 equals 1
// - Two-backplane mode: 0=2 and 1=3
// - Static mode: all backplanes identical
// - 32 segments from timing and register
// - RAM one is on, zero off
// - Columns to segments, rows to backplanes
// - Static: byte into row 0, eight columns
// - Two-backplane: four 2-bit column words
// - Three-backplane: three 3-bit words, last bit kept
// - Four-backplane: two 4-bit column words
// - Select low: internal clock driven out
// - Pointer advances 8, 4, 3 or 2
module lcdt_top import lcdt_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic clock_source_select,
   input wire logic clk_pin_in,
   output logic clk_pin_out,
   output logic clk_pin_oe,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe,
   input wire lcdt_mode_t drive_mode,
   input wire logic ptr_load,
   input wire logic [4:0] ptr_value,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic [1:0] backplane_out_0,
   output logic [1:0] backplane_out_1,
   output logic [1:0] backplane_out_2,
   output logic [1:0] backplane_out_3,
   output logic [31:0][1:0] segment_outputs,
   output logic frame_frequency
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [2:0] osc_cnt;
      logic osc_lvl;
      logic pin_prev;
      logic [4:0] div_cnt;
      logic sync_drv;
      logic [31:0][3:0] disp;
      logic [3:0][1:0] bp;
      logic [31:0][1:0] seg;
      logic frame_lvl;
      logic clk_out;
      logic clk_oe;
   } lcdt_state_t;

   lcdt_state_t s;
   lcdt_state_t next_s;
   logic [31:0][3:0] ram_bits;
   logic tick;
   logic frame_start;
   logic sync_seen;

   // ==========================================================
   // Display RAM and byte packing
   lcdt_ram u_ram (
      .clk(clk),
      .rst(rst),
      .drive_mode(drive_mode),
      .ptr_load(ptr_load),
      .ptr_value(ptr_value),
      .byte_valid(byte_valid),
      .byte_data(byte_data),
      .ram_bits(ram_bits),
      .ptr()
   );

   // ==========================================================
   // Decoding helpers
   // Row being scanned at a given frame count
   function automatic logic [1:0] row_of(lcdt_mode_t m, logic [4:0] d);
      logic [4:0] h;
      logic [1:0] r;
      h = (d >= `LCDT_HALF_FRAME) ? 5'(d - `LCDT_HALF_FRAME) : d;
      r = 2'h0;
      unique case (m)
         lcdt_static: r = 2'h0;
         lcdt_mux2: r = 2'(h / `LCDT_SLOT_MUX2);
         lcdt_mux3: r = 2'(h / `LCDT_SLOT_MUX3);
         lcdt_mux4: r = 2'(h / `LCDT_SLOT_MUX4);
      endcase
      return r;
   endfunction : row_of

   // Logical row served by a physical backplane output
   function automatic logic [1:0] phys_row(lcdt_mode_t m, logic [1:0] p);
      logic [1:0] r;
      r = p;
      unique case (m)
         lcdt_static: r = 2'h0;
         lcdt_mux2: r = {1'b0, p[0]};
         lcdt_mux3: r = (p == 2'h3) ? 2'h1 : p;
         lcdt_mux4: r = p;
      endcase
      return r;
   endfunction : phys_row

   // Backplane level for selected or idle row
   function automatic lcdt_level_t bp_level(logic sel, logic pol);
      lcdt_level_t l;
      if (sel) begin
         l = pol ? `LCDT_LVL_VLCD : `LCDT_LVL_VSS;
      end else begin
         l = pol ? `LCDT_LVL_THIRD : `LCDT_LVL_TWO_THIRD;
      end
      return l;
   endfunction : bp_level

   // Segment level for an on or off element
   function automatic lcdt_level_t seg_level(lcdt_mode_t m, logic on,
                                            logic pol);
      lcdt_level_t l;
      if (on) begin
         l = pol ? `LCDT_LVL_VSS : `LCDT_LVL_VLCD;
      end else if (m == lcdt_static) begin
         l = pol ? `LCDT_LVL_VLCD : `LCDT_LVL_VSS;
      end else begin
         l = pol ? `LCDT_LVL_TWO_THIRD : `LCDT_LVL_THIRD;
      end
      return l;
   endfunction : seg_level

   // ==========================================================
   // Clock selection, frame division and sync
   always_comb begin
      logic int_tick;
      logic ext_tick;
      logic [1:0] row;
      logic pol;
      int_tick = 1'b0;
      ext_tick = 1'b0;
      row = 2'h0;
      pol = 1'b0;
      next_s = s;
      // Free running internal oscillator
      if (s.osc_cnt == `LCDT_OSC_HALF_LAST) begin
         next_s.osc_cnt = 3'h0;
         next_s.osc_lvl = ~s.osc_lvl;
      end else begin
         next_s.osc_cnt = 3'(s.osc_cnt + 3'h1);
      end
      int_tick = (s.osc_cnt == `LCDT_OSC_HALF_LAST) && !s.osc_lvl;
      // Rising edge of the clock pin when it is an input
      next_s.pin_prev = clk_pin_in;
      ext_tick = clk_pin_in && !s.pin_prev;
      tick = clock_source_select ? ext_tick : int_tick;
      next_s.clk_out = s.osc_lvl;
      next_s.clk_oe = !clock_source_select;
      // Frame counter over 24 active clocks
      frame_start = tick && (s.div_cnt == `LCDT_FRAME_LAST);
      sync_seen = !sync_in && !s.sync_drv;
      if (sync_seen) begin
         next_s.div_cnt = 5'h00;
      end else if (tick) begin
         next_s.div_cnt = frame_start ? 5'h00 : 5'(s.div_cnt + 5'h01);
      end
      next_s.sync_drv = frame_start;
      next_s.frame_lvl = (s.div_cnt < `LCDT_HALF_FRAME);
      // Display register loaded once per frame
      if (frame_start) begin
         next_s.disp = ram_bits;
      end
      // Backplane and segment waveforms
      row = row_of(drive_mode, s.div_cnt);
      pol = (s.div_cnt >= `LCDT_HALF_FRAME);
      for (int p = 0; p < `LCDT_ROWS; p++) begin
         next_s.bp[p] = bp_level(phys_row(drive_mode, 2'(p)) == row,
                                 pol);
      end
      for (int c = 0; c < `LCDT_COLS; c++) begin
         next_s.seg[c] = seg_level(drive_mode, s.disp[c][row],
                                   pol);
      end
   end

   // Register the state
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign clk_pin_out = s.clk_out;
   assign clk_pin_oe = s.clk_oe;
   assign sync_out = 1'b0; // Open drain, only pulls low
   assign sync_oe = s.sync_drv;
   assign backplane_out_0 = s.bp[0];
   assign backplane_out_1 = s.bp[1];
   assign backplane_out_2 = s.bp[2];
   assign backplane_out_3 = s.bp[3];
   assign segment_outputs = s.seg;
   assign frame_frequency = s.frame_lvl;

   // ==========================================================
   // Checks
   a_ext_clock_in: assert property (@(posedge clk) disable iff (rst)
      clock_source_select |=> !clk_pin_oe)
      else $error("clock pin driven in external mode");

   a_int_clock_out: assert property (@(posedge clk) disable iff (rst)
      !clock_source_select ##1 !clock_source_select
      |-> clk_pin_oe && clk_pin_out == $past(s.osc_lvl))
      else $error("internal clock not presented on pin");

   a_frame_wrap: assert property (@(posedge clk) disable iff (rst)
      frame_start |-> $past(s.div_cnt) == `LCDT_FRAME_LAST - 5'h01
         || $past(s.div_cnt) == `LCDT_FRAME_LAST)
      else $error("frame ended at wrong count");

   a_sync_pulse: assert property (@(posedge clk) disable iff (rst)
      frame_start && !sync_seen |=> sync_oe ##1 !sync_oe)
      else $error("sync pulse not one cycle after frame end");

   a_sync_align: assert property (@(posedge clk) disable iff (rst)
      sync_seen |=> s.div_cnt == 5'h00)
      else $error("foreign sync did not restart frame");

   a_disp_latch: assert property (@(posedge clk) disable iff (rst)
      frame_start |=> s.disp == $past(ram_bits))
      else $error("display register not loaded at frame");

   a_bp_mux3: assert property (@(posedge clk) disable iff (rst)
      $past(drive_mode) == lcdt_mux3 && !$past(rst)
      |-> backplane_out_3 == backplane_out_1)
      else $error("backplane 3 differs from 1");

   a_bp_mux2: assert property (@(posedge clk) disable iff (rst)
      $past(drive_mode) == lcdt_mux2 && !$past(rst)
      |-> backplane_out_0 == backplane_out_2
         && backplane_out_1 == backplane_out_3)
      else $error("paired backplanes differ");

   a_bp_static: assert property (@(posedge clk) disable iff (rst)
      $past(drive_mode) == lcdt_static && !$past(rst)
      |-> backplane_out_0 == backplane_out_1
         && backplane_out_0 == backplane_out_2
         && backplane_out_0 == backplane_out_3)
      else $error("static backplanes differ");

   a_seg_on: assert property (@(posedge clk) disable iff (rst)
      $past(drive_mode) == lcdt_static && !$past(rst)
         && $past(s.disp[0][0])
      |-> segment_outputs[0] != backplane_out_0)
      else $error("on segment in phase with backplane");

   a_seg_off: assert property (@(posedge clk) disable iff (rst)
      $past(drive_mode) == lcdt_static && !$past(rst)
         && !$past(s.disp[8][0])
      |-> segment_outputs[8] == backplane_out_0)
      else $error("off segment out of phase with backplane");

   // Exactly one backplane at a full level in four-row scanning
   a_mux4_one_row: assert property (@(posedge clk) disable iff (rst)
      $past(drive_mode) == lcdt_mux4 && !$past(rst)
      |-> $countones({backplane_out_0[1] ~^ backplane_out_0[0],
         backplane_out_1[1] ~^ backplane_out_1[0],
         backplane_out_2[1] ~^ backplane_out_2[0],
         backplane_out_3[1] ~^ backplane_out_3[0]}) == 1)
      else $error("not exactly one backplane selected");

   a_div_range: assert property (@(posedge clk) disable iff (rst)
      s.div_cnt <= `LCDT_FRAME_LAST)
      else $error("frame counter out of range");

   a_disp_hold: assert property (@(posedge clk) disable iff (rst)
      !frame_start |=> s.disp == $past(s.disp))
      else $error("display register changed inside a frame");

   a_frame_level: assert property (@(posedge clk) disable iff (rst)
      frame_start |-> !frame_frequency ##2 frame_frequency)
      else $error("frame level not aligned to frame start");

   c_frame: cover property (@(posedge clk) disable iff (rst)
      frame_start);
   c_sync: cover property (@(posedge clk) disable iff (rst)
      sync_seen);
   c_ext_frame: cover property (@(posedge clk) disable iff (rst)
      clock_source_select && frame_start);
   c_mux4_write: cover property (@(posedge clk) disable iff (rst)
      byte_valid && drive_mode == lcdt_mux4);

endmodule : lcdt_top
`default_nettype wire

/* File: verilog/lcdt_ram_fix_note.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: bench/lcdt_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side: clock source, cascaded peer and shared sync wire
module lcdt_panel_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin_oe,
   input wire logic pin_out,
   input wire logic sync_oe,
   input wire logic peer_pull,
   output logic pin_level,
   output logic sync_level
);
   logic ext_clk;
   logic [1:0] div;

   // Free-running source, rising edges six cycles apart
   always_ff @(posedge clk) begin
      if (rst) begin
         div <= 2'h0;
         ext_clk <= 1'b0;
      end else if (div == 2'h2) begin
         div <= 2'h0;
         ext_clk <= ~ext_clk;
      end else begin
         div <= div + 2'h1;
      end
   end

   // Pin level follows whoever drives it
   assign pin_level = pin_oe ? pin_out : ext_clk;
   // Pulled-up wire, any party pulls it low
   assign sync_level = ~(sync_oe | peer_pull);
endmodule : lcdt_panel_model
`default_nettype wire

/* File: bench/tb_lcd_frame_timing_and_segment_ram.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for frame timing, drive levels and display RAM
module tb_lcd_frame_timing_and_segment_ram import lcdt_pkg::*;;
   logic clk, rst, clock_source_select, clk_pin_in, clk_pin_out;
   logic clk_pin_oe, sync_in, sync_out, sync_oe, ptr_load;
   logic byte_valid, frame_frequency, peer_pull;
   lcdt_mode_t drive_mode;
   logic [4:0] ptr_value, ram_ptr;
   logic [7:0] byte_data;
   logic [1:0] backplane_out_0, backplane_out_1;
   logic [1:0] backplane_out_2, backplane_out_3;
   logic [31:0][1:0] segment_outputs;
   logic [31:0][3:0] ram_bits, exp_ram;
   int errors, compares;

   lcdt_top u_dut (.clk, .rst, .clock_source_select, .clk_pin_in,
      .clk_pin_out, .clk_pin_oe, .sync_in, .sync_out, .sync_oe,
      .drive_mode, .ptr_load, .ptr_value, .byte_valid, .byte_data,
      .backplane_out_0, .backplane_out_1, .backplane_out_2,
      .backplane_out_3, .segment_outputs, .frame_frequency);
   // RAM bitmap and pointer observed inside the design
   assign ram_bits = u_dut.ram_bits;
   assign ram_ptr = u_dut.u_ram.ptr;
   lcdt_panel_model u_panel (.clk, .rst, .pin_oe(clk_pin_oe),
      .pin_out(clk_pin_out), .sync_oe, .peer_pull,
      .pin_level(clk_pin_in), .sync_level(sync_in));

   // ==========================================================
   // Shared helpers
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   // Counts cycles up to the next frame pulse, and high frame cycles
   task automatic span(output int len, output int hi);
      len = 0;
      hi = 0;
      do begin
         @(posedge clk);
         #1;
         len++;
         hi += int'(frame_frequency === 1'b1);
         if (len > 400) begin
            errors++;
            $display("[ERR] %0t no frame pulse", $time);
            conclude();
         end
      end while (sync_oe !== 1'b1);
   endtask : span

   // Loads the pointer, sends one byte and updates the expected bitmap
   task automatic put_byte(input lcdt_mode_t m, input logic [4:0] p,
         input logic [7:0] d);
      int n;
      n = int'(m) + 1;
      @(posedge clk);
      drive_mode <= m;
      ptr_load <= 1'b1;
      ptr_value <= p;
      @(posedge clk);
      ptr_load <= 1'b0;
      byte_valid <= 1'b1;
      byte_data <= d;
      @(posedge clk);
      byte_valid <= 1'b0;
      for (int i = 0; i < 8; i++)
         exp_ram[5'(p + i / n)][i % n] = d[7 - i];
      #1;
      check(ram_bits, exp_ram);
      check(ram_ptr, 5'(p + (8 + n - 1) / n));
   endtask : put_byte

   // ==========================================================
   // Scenarios
   task automatic test_ram;
      put_byte(lcdt_mux4, 5'h06, 8'hff);
      // Mux3 byte keeps the column 6, row 2 bit set by the first mux4 byte
      for (int k = 0; k < 4; k++)
         put_byte(lcdt_mode_t'(k), 5'h04, 8'hb5 ^ 8'(k * 8'h33));
      put_byte(lcdt_static, 5'h1c, 8'h3c);
      // Pointer load wins over a byte in the same cycle
      @(posedge clk);
      ptr_load <= 1'b1;
      ptr_value <= 5'h11;
      byte_valid <= 1'b1;
      byte_data <= 8'h00;
      @(posedge clk);
      ptr_load <= 1'b0;
      byte_valid <= 1'b0;
      #1;
      check(ram_bits, exp_ram);
      check(ram_ptr, 5'h11);
      $display("test ram done");
   endtask : test_ram

   task automatic test_clock(input logic ext, input int tick);
      int len, hi, rises;
      logic prev;
      @(posedge clk);
      clock_source_select <= ext;
      span(len, hi);
      span(len, hi);
      check(clk_pin_oe, !ext);
      span(len, hi);
      check(len, 24 * tick);
      check(hi, 12 * tick);
      // Pin clock rises once per frame tick in internal mode
      if (!ext) begin
         rises = 0;
         prev = clk_pin_out;
         for (int c = 0; c < 192; c++) begin
            @(posedge clk);
            #1;
            rises += int'(clk_pin_out === 1'b1 && prev === 1'b0);
            prev = clk_pin_out;
         end
         check(rises, 24);
      end
      $display("test clock source %0d done", ext);
   endtask : test_clock

   task automatic test_backplanes;
      int len, hi, bad, diff;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         drive_mode <= lcdt_mode_t'(k);
         span(len, hi);
         bad = 0;
         diff = 0;
         for (int c = 0; c < 192; c++) begin
            @(posedge clk);
            #1;
            diff += int'(backplane_out_0 !== backplane_out_1);
            case (k)
               0: bad += int'(backplane_out_0 !== backplane_out_1 ||
                     backplane_out_1 !== backplane_out_2 ||
                     backplane_out_2 !== backplane_out_3);
               1: bad += int'(backplane_out_0 !== backplane_out_2 ||
                     backplane_out_1 !== backplane_out_3);
               2: bad += int'(backplane_out_3 !== backplane_out_1);
               default: bad += int'($countones({
                     backplane_out_0[1] ~^ backplane_out_0[0],
                     backplane_out_1[1] ~^ backplane_out_1[0],
                     backplane_out_2[1] ~^ backplane_out_2[0],
                     backplane_out_3[1] ~^ backplane_out_3[0]}) != 1);
            endcase
         end
         check(bad, 0);
         check(diff > 0, k != 0);
      end
      $display("test backplanes done");
   endtask : test_backplanes

   task automatic test_segments;
      int len, hi, bad;
      put_byte(lcdt_static, 5'h00, 8'hff);
      put_byte(lcdt_static, 5'h08, 8'h00);
      span(len, hi);
      span(len, hi);
      bad = 0;
      for (int c = 0; c < 192; c++) begin
         @(posedge clk);
         #1;
         bad += int'(segment_outputs[0] === backplane_out_0);
         bad += int'(segment_outputs[8] !== backplane_out_0);
      end
      check(bad, 0);
      $display("test segments done");
   endtask : test_segments

   task automatic test_sync;
      int len, hi;
      span(len, hi);
      repeat (70) @(posedge clk);
      peer_pull <= 1'b1;
      @(posedge clk);
      peer_pull <= 1'b0;
      span(len, hi);
      check(len >= 138 && len <= 152, 1'b1);
      @(posedge clk);
      #1;
      check(sync_oe, 1'b0);
      check(sync_out, 1'b0);
      $display("test sync done");
   endtask : test_sync

   // ==========================================================
   // Clock, reset and main sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      errors = 0;
      compares = 0;
      exp_ram = '0;
      rst = 1'b1;
      clock_source_select = 1'b0;
      drive_mode = lcdt_static;
      ptr_load = 1'b0;
      ptr_value = 5'h00;
      byte_valid = 1'b0;
      byte_data = 8'h00;
      peer_pull = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      test_ram();
      test_clock(1'b0, 8);
      test_backplanes();
      test_segments();
      test_clock(1'b1, 6);
      test_sync();
      conclude();
   end
endmodule : tb_lcd_frame_timing_and_segment_ram
`default_nettype wire
